// *** bench/sbsa_master.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Bus master model, data line is open drain with pull-up
// ----------------------------------------------------------------
module sbsa_master
(
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // Both lines released while idle
    initial
    begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end

    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_o = 1'h1;
        #100 scl_o = 1'h1;
        #200 sda_o = 1'h0;
        #200 scl_o = 1'h0;
    endtask

    // Stop: data rises while clock high
    task automatic stop();
        sda_o = 1'h0;
        #200 scl_o = 1'h1;
        #200 sda_o = 1'h1;
        #200;
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic m_ack,
                        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_o = d[i];
            #200 scl_o = 1'h1;
            #100 r[i] = sda_i;
            #100 scl_o = 1'h0;
        end
        sda_o = ~m_ack;
        #200 scl_o = 1'h1;
        #100 ack = ~sda_i;
        #100 scl_o = 1'h0;
    endtask
endmodule

// *** bench/serial_bus_slave_addressing_test.sv ***
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
 bad_count++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module serial_bus_slave_addressing_test;
    logic       clk_i = 1'h0;
    logic       lnk_clk_i = 1'h0;
    logic       rst_n_i = 1'h0;
    logic       gc_en_i = 1'h0;
    logic [2:0] hw_addr_i = 3'h3;
    logic       scl, m_sda, sda_o, sda_oe_o, rw_o, a;
    logic       ev_a, ev_g, ev_h, ev_r, ev_p, ev_b;
    logic [7:0] rx_data_o, r;
    logic [6:0] own_addr_o;
    int         bad_count, samples_checked, cyc;
    int         cnt [6];
    wire        sda = m_sda & (sda_oe_o ? sda_o : 1'h1);

    sbsa_master i_sbsa_master (.sda_i(sda), .scl_o(scl), .sda_o(m_sda));
    sbsa_slave i_sbsa_slave (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .lnk_clk_i(lnk_clk_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .hw_addr_i(hw_addr_i), .gc_en_i(gc_en_i),
        .addr_evt_o(ev_a), .rw_o(rw_o), .gc_evt_o(ev_g),
        .hw_call_evt_o(ev_h), .gc_reset_evt_o(ev_r), .prog_evt_o(ev_p),
        .byte_evt_o(ev_b), .rx_data_o(rx_data_o), .own_addr_o(own_addr_o));

    // Clocks, system and link, unrelated in phase
    initial forever #10 clk_i = ~clk_i;
    initial forever #7.5 lnk_clk_i = ~lnk_clk_i;

    // Event pulse counters and hang guard
    always @(posedge clk_i)
    begin
        {cnt[5], cnt[3], cnt[2], cnt[1]} <= {cnt[5] + ev_a, cnt[3] + ev_h,
                                             cnt[2] + ev_r, cnt[1] + ev_p};
        cnt[0] <= cnt[0] + ev_b;
        cnt[4] <= cnt[4] + ev_g;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic b(input logic [7:0] d, input logic ma);
        i_sbsa_master.xfer(d, ma, r, a);
    endtask

    // General call, then a second byte
    task automatic gc(input logic [7:0] code);
        i_sbsa_master.start();
        b(8'h00, 1'h0);
        `CHK("gc ack", 1'h1, a)
        b(code, 1'h0);
    endtask

    task automatic t_wr_rd();
        i_sbsa_master.start();
        b(8'ha0, 1'h0);
        `CHK("addr ack", 1'h1, a)
        b(8'h5a, 1'h0);
        `CHK("data ack", 1'h1, a)
        i_sbsa_master.start();
        b(8'ha1, 1'h0);
        `CHK("read ack", 1'h1, a)
        b(8'hff, 1'h1);
        `CHK("read data", 8'h5a, r)
        b(8'hff, 1'h0);
        `CHK("read again", 8'h5a, r)
        `CHK("dir", 1'h1, rw_o)
        i_sbsa_master.stop();
        `CHK("rx", 8'h5a, rx_data_o)
        `CHK("addr evts", 2, cnt[5])
        `CHK("byte evts", 1, cnt[0])
    endtask

    task automatic t_refused();
        logic [7:0] bad [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
                                 8'h05, 8'h0e, 8'hfe, 8'hf1, 8'ha2};
        foreach (bad[i])
        begin
            i_sbsa_master.start();
            b(bad[i], 1'h0);
            `CHK("refused", 1'h0, a)
        end
        i_sbsa_master.start();
        b(8'ha0, 1'h0);
        `CHK("after sr", 1'h1, a)
        i_sbsa_master.stop();
    endtask

    task automatic t_gc();
        gc(8'h00);
        `CHK("code 00", 1'h0, a)
        gc(8'h08);
        `CHK("code 08", 1'h0, a)
        gc(8'h04);
        `CHK("code 04", 1'h1, a)
        i_sbsa_master.stop();
        `CHK("latched", 7'h53, own_addr_o)
        gc(8'h0b);
        `CHK("hw call", 1'h1, a)
        i_sbsa_master.stop();
        `CHK("hw master", 8'h0b, rx_data_o)
        `CHK("hw evts", 1, cnt[3])
        gc(8'h02);
        `CHK("code 02", 1'h1, a)
        b(8'hac, 1'h0);
        `CHK("prog ack", 1'h1, a)
        b(8'h3c, 1'h0);
        `CHK("bad byte", 1'h0, a)
        i_sbsa_master.stop();
        `CHK("programmed", 7'h56, own_addr_o)
        `CHK("prog evts", 2, cnt[1])
        @(negedge clk_i) hw_addr_i = 3'h5;
        gc(8'h06);
        `CHK("code 06", 1'h1, a)
        b(8'h11, 1'h0);
        `CHK("post reset", 1'h0, a)
        i_sbsa_master.stop();
        `CHK("reloaded", 7'h55, own_addr_o)
        `CHK("reset evts", 1, cnt[2])
        `CHK("gc evts", 6, cnt[4])
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(negedge clk_i);
        rst_n_i = 1'h1;
        repeat (10) @(negedge clk_i);
        `CHK("released", 1'h0, sda_oe_o)
        `CHK("own", 7'h50, own_addr_o)
        t_wr_rd();
        t_refused();
        @(negedge clk_i) gc_en_i = 1'h1;
        repeat (10) @(negedge clk_i);
        t_gc();
        stop_test();
    end
endmodule

// *** shared/sbsa_pkg.sv ***
package sbsa_pkg;

    // ----------------------------------------------------------------
    // Address layout
    // ----------------------------------------------------------------
    localparam int          SBSA_PROG_W    = 3;
    localparam logic [3:0]  SBSA_FIX_ADDR  = 4'ha;  // Fixed address portion
    localparam logic [2:0]  SBSA_PROG_RST  = 3'h0;  // Programmable part reset
    localparam logic [3:0]  SBSA_GRP_SPEC  = 4'h0;  // Special group 0000xxx
    localparam logic [3:0]  SBSA_GRP_EXT   = 4'hf;  // Extension group 1111xxx
    localparam logic [7:0]  SBSA_GC_BYTE   = 8'h00; // General call, write
    localparam logic [7:0]  SBSA_START_BYT = 8'h01; // Start byte
    localparam logic [6:0]  SBSA_TRIW_ADDR = 7'h01; // Three-wire format
    localparam logic [6:0]  SBSA_ALT_ADDR  = 7'h02; // Other bus format
    localparam logic [6:0]  SBSA_EXT_ADDR  = 7'h7f; // Extended addressing

    // ----------------------------------------------------------------
    // General call second byte codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  SBSA_GC_RESET  = 8'h06;
    localparam logic [7:0]  SBSA_GC_SWPROG = 8'h02;
    localparam logic [7:0]  SBSA_GC_HWLAT  = 8'h04;
    localparam logic [7:0]  SBSA_GC_NONE   = 8'h00;

    // ----------------------------------------------------------------
    // Bit counter marks and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0]  SBSA_BIT_ACK   = 4'h8;  // Eight bits shifted
    localparam logic [3:0]  SBSA_BIT_END   = 4'h9;  // Inside acknowledge slot
    localparam logic [7:0]  SBSA_DATA_RST  = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_GC2,
        S_PROG,
        S_RX,
        S_TX,
        S_NACK
    } sbsa_state_t;

    typedef struct packed {
        logic addr;
        logic gc;
        logic hw_call;
        logic gc_reset;
        logic prog;
        logic rx_byte;
    } sbsa_evt_t;

endpackage

// *** verilog/sbsa_evt_sync.sv ***
`timescale 1ns/100ps
module sbsa_evt_sync
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire sbsa_pkg::sbsa_evt_t tgl_i,
    output sbsa_pkg::sbsa_evt_t    pulse_o
);

    // ----------------------------------------------------------------
    // Toggle crossing, one synchroniser per event
    // ----------------------------------------------------------------
    logic [$bits(sbsa_pkg::sbsa_evt_t)-1:0] q1;
    logic [$bits(sbsa_pkg::sbsa_evt_t)-1:0] q2;
    logic [$bits(sbsa_pkg::sbsa_evt_t)-1:0] q3;

    genvar i;
    generate
        for (i = 0; i < $bits(sbsa_pkg::sbsa_evt_t); i++)
        begin : g_bit
            // Two stages, then a history stage for the edge
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    q1[i] <= 1'b0;
                    q2[i] <= 1'b0;
                    q3[i] <= 1'b0;
                end
                else
                begin
                    q1[i] <= tgl_i[i];
                    q2[i] <= q1[i];
                    q3[i] <= q2[i];
                end
            end
        end
    endgenerate

    // Edge of each synchronised toggle
    assign pulse_o = q2 ^ q3; // One pulse per toggle

endmodule

// *** verilog/sbsa_slave.sv ***
`timescale 1ns/100ps
module sbsa_slave
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       lnk_clk_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [2:0] hw_addr_i,
    input  wire logic       gc_en_i,
    output logic            addr_evt_o,
    output logic            rw_o,
    output logic            gc_evt_o,
    output logic            hw_call_evt_o,
    output logic            gc_reset_evt_o,
    output logic            prog_evt_o,
    output logic            byte_evt_o,
    output logic [7:0]      rx_data_o,
    output logic [6:0]      own_addr_o
);

    // ----------------------------------------------------------------
    // Address classification
    // ----------------------------------------------------------------
    // Reserved groups must never be taken as an ordinary address
    function automatic logic addr_reserved(input logic [6:0] a);
        addr_reserved = (a[6:3] == sbsa_pkg::SBSA_GRP_SPEC) ||
                        (a[6:3] == sbsa_pkg::SBSA_GRP_EXT);
    endfunction

    // ----------------------------------------------------------------
    // Link domain reset and input synchronisers
    // ----------------------------------------------------------------
    logic       lrst_q1;
    logic       lrst_n;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [2:0] hw_q1;
    logic [2:0] hw_s;
    logic       gce_q1;
    logic       gc_en;
    logic       scl_p;
    logic       sda_p;

    // Reset reaches the link side through two stages
    always_ff @(posedge lnk_clk_i)
    begin
        lrst_q1 <= rst_n_i;
        lrst_n  <= lrst_q1;
    end

    // Pins and the enable pass two stages; a third keeps pin history
    always_ff @(posedge lnk_clk_i)
    begin
        if (!lrst_n)
        begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_p  <= 1'b1;
            sda_p  <= 1'b1;
            hw_q1  <= 3'h0;
            hw_s   <= 3'h0;
            gce_q1 <= 1'b0;
            gc_en  <= 1'b0;
        end
        else
        begin
            scl_sy <= {scl_sy[0], scl_i};
            sda_sy <= {sda_sy[0], sda_i};
            scl_p  <= scl_sy[1];
            sda_p  <= sda_sy[1];
            hw_q1  <= hw_addr_i;
            hw_s   <= hw_q1;
            gce_q1 <= gc_en_i;
            gc_en  <= gce_q1;
        end
    end

    // ----------------------------------------------------------------
    // Bus conditions
    // ----------------------------------------------------------------
    wire scl_s   = scl_sy[1];
    wire sda_s   = sda_sy[1];
    wire scl_hi  = scl_s & scl_p;
    wire start_c = scl_hi & sda_p & ~sda_s;
    wire stop_c  = scl_hi & ~sda_p & sda_s;
    wire rise    = scl_s & ~scl_p;
    wire fall    = ~scl_s & scl_p;

    // ----------------------------------------------------------------
    // Link state
    // ----------------------------------------------------------------
    sbsa_pkg::sbsa_state_t st;
    sbsa_pkg::sbsa_state_t next_st;
    logic [3:0]            cnt;
    logic [3:0]            next_cnt;
    logic [7:0]            sh;
    logic [7:0]            next_sh;
    logic [7:0]            tx;
    logic [7:0]            next_tx;
    logic [7:0]            data;
    logic [7:0]            next_data;
    logic [2:0]            prog;
    logic [2:0]            next_prog;
    logic                  oe;
    logic                  next_oe;
    logic                  ack_us;
    logic                  next_ack_us;
    logic                  mack;
    logic                  next_mack;
    logic                  rw;
    logic                  next_rw;
    sbsa_pkg::sbsa_evt_t   ev;
    sbsa_pkg::sbsa_evt_t   ev_tgl;

    // ----------------------------------------------------------------
    // Byte decode
    // ----------------------------------------------------------------
    wire [6:0] own     = {sbsa_pkg::SBSA_FIX_ADDR, prog};
    wire       decide  = fall && (cnt == sbsa_pkg::SBSA_BIT_ACK);
    wire       ack_end = fall && (cnt == sbsa_pkg::SBSA_BIT_END);
    wire       hit_own = (sh[7:1] == own) && !addr_reserved(own);
    wire       hit_gc  = (sh == sbsa_pkg::SBSA_GC_BYTE) && gc_en;
    wire       fix_ok  = (sh[7:4] == sbsa_pkg::SBSA_FIX_ADDR);
    wire       shifting = rise && (cnt < sbsa_pkg::SBSA_BIT_ACK);

    // ----------------------------------------------------------------
    // Next state of the bit engine
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st     = st;
        next_cnt    = cnt;
        next_sh     = sh;
        next_tx     = tx;
        next_data   = data;
        next_prog   = prog;
        next_oe     = oe;
        next_ack_us = ack_us;
        next_mack   = mack;
        next_rw     = rw;
        ev          = '0;
        if (start_c)
        begin
            next_st     = sbsa_pkg::S_ADDR;
            next_cnt    = 4'h0;
            next_oe     = 1'b0;
            next_ack_us = 1'b0;
        end
        else if (stop_c)
        begin
            next_st     = sbsa_pkg::S_IDLE;
            next_cnt    = 4'h0;
            next_oe     = 1'b0;
            next_ack_us = 1'b0;
        end
        else if (st != sbsa_pkg::S_IDLE)
        begin
            // Sample MSB first on each rising clock
            if (shifting)
            begin
                next_sh  = {sh[6:0], sda_s};
                next_tx  = {tx[6:0], 1'b0};
                next_cnt = 4'(cnt + 4'h1);
            end
            if (rise && (cnt == sbsa_pkg::SBSA_BIT_END))
                next_mack = ~sda_s;
            if (fall && (cnt < sbsa_pkg::SBSA_BIT_ACK) &&
                (st == sbsa_pkg::S_TX))
                next_oe = ~tx[7];
            if (decide)
            begin
                next_cnt = sbsa_pkg::SBSA_BIT_END;
                next_oe  = 1'b0;
                case (st)
                    sbsa_pkg::S_ADDR:
                    begin
                        next_rw = sh[0];
                        if (hit_own)
                        begin
                            next_oe     = 1'b1;
                            next_ack_us = 1'b1;
                            next_tx     = data;
                            next_st     = sh[0] ? sbsa_pkg::S_TX
                                                : sbsa_pkg::S_RX;
                            ev.addr     = 1'b1;
                        end
                        else if (hit_gc)
                        begin
                            next_oe     = 1'b1;
                            next_ack_us = 1'b1;
                            next_st     = sbsa_pkg::S_GC2;
                            ev.gc       = 1'b1;
                        end
                        else
                            next_st = sbsa_pkg::S_IDLE;
                    end
                    sbsa_pkg::S_GC2:
                    begin
                        if (sh[0])
                        begin
                            next_oe     = 1'b1;
                            next_ack_us = 1'b1;
                            next_data   = sh;
                            next_st     = sbsa_pkg::S_RX;
                            ev.hw_call  = 1'b1;
                        end
                        else if (sh == sbsa_pkg::SBSA_GC_RESET)
                        begin
                            next_oe     = 1'b1;
                            next_ack_us = 1'b1;
                            next_prog   = hw_s;
                            next_data   = sbsa_pkg::SBSA_DATA_RST;
                            next_st     = sbsa_pkg::S_NACK;
                            ev.gc_reset = 1'b1;
                        end
                        else if (sh == sbsa_pkg::SBSA_GC_SWPROG)
                        begin
                            next_oe     = 1'b1;
                            next_ack_us = 1'b1;
                            next_st     = sbsa_pkg::S_PROG;
                        end
                        else if (sh == sbsa_pkg::SBSA_GC_HWLAT)
                        begin
                            next_oe     = 1'b1;
                            next_ack_us = 1'b1;
                            next_prog   = hw_s;
                            next_st     = sbsa_pkg::S_NACK;
                            ev.prog     = 1'b1;
                        end
                        else
                            next_st = sbsa_pkg::S_IDLE;
                    end
                    sbsa_pkg::S_PROG:
                    begin
                        // Only bytes carrying our fixed part program us
                        if (fix_ok)
                        begin
                            next_oe     = 1'b1;
                            next_ack_us = 1'b1;
                            next_prog   = sh[3:1];
                            ev.prog     = 1'b1;
                        end
                    end
                    sbsa_pkg::S_RX:
                    begin
                        next_oe     = 1'b1;
                        next_ack_us = 1'b1;
                        next_data   = sh;
                        ev.rx_byte  = 1'b1;
                    end
                    default:
                    begin
                        next_ack_us = 1'b0;
                    end
                endcase
            end
            // Leaving the acknowledge slot
            if (ack_end)
            begin
                next_cnt    = 4'h0;
                next_ack_us = 1'b0;
                if (st == sbsa_pkg::S_TX)
                begin
                    if (ack_us || mack)
                    begin
                        if (!ack_us)
                            next_tx = data;
                        next_oe = ack_us ? ~tx[7] : ~data[7];
                    end
                    else
                    begin
                        next_oe = 1'b0;
                        next_st = sbsa_pkg::S_IDLE;
                    end
                end
                else
                    next_oe = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Link state registers
    // ----------------------------------------------------------------
    always_ff @(posedge lnk_clk_i)
    begin
        if (!lrst_n)
        begin
            st     <= sbsa_pkg::S_IDLE;
            cnt    <= 4'h0;
            sh     <= sbsa_pkg::SBSA_DATA_RST;
            tx     <= sbsa_pkg::SBSA_DATA_RST;
            data   <= sbsa_pkg::SBSA_DATA_RST;
            prog   <= sbsa_pkg::SBSA_PROG_RST;
            oe     <= 1'b0;
            ack_us <= 1'b0;
            mack   <= 1'b0;
            rw     <= 1'b0;
            ev_tgl <= '0;
        end
        else
        begin
            st     <= next_st;
            cnt    <= next_cnt;
            sh     <= next_sh;
            tx     <= next_tx;
            data   <= next_data;
            prog   <= next_prog;
            oe     <= next_oe;
            ack_us <= next_ack_us;
            mack   <= next_mack;
            rw     <= next_rw;
            ev_tgl <= ev_tgl ^ ev;
        end
    end

    // Open-drain pad: only ever pulls low
    always_ff @(posedge lnk_clk_i)
        sda_o <= 1'b0;
    assign sda_oe_o = oe;

    // ----------------------------------------------------------------
    // Crossing to the system clock
    // ----------------------------------------------------------------
    sbsa_pkg::sbsa_evt_t pulse;

    sbsa_evt_sync u_sync
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .tgl_i   (ev_tgl),
        .pulse_o (pulse)
    );

    // Link words are stable long before their toggle lands
    wire take_data = pulse.rx_byte | pulse.hw_call;

    // Event outputs and captured words
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            addr_evt_o     <= 1'b0;
            rw_o           <= 1'b0;
            gc_evt_o       <= 1'b0;
            hw_call_evt_o  <= 1'b0;
            gc_reset_evt_o <= 1'b0;
            prog_evt_o     <= 1'b0;
            byte_evt_o     <= 1'b0;
            rx_data_o      <= sbsa_pkg::SBSA_DATA_RST;
            own_addr_o     <= {sbsa_pkg::SBSA_FIX_ADDR,
                               sbsa_pkg::SBSA_PROG_RST};
        end
        else
        begin
            addr_evt_o     <= pulse.addr;
            gc_evt_o       <= pulse.gc;
            hw_call_evt_o  <= pulse.hw_call;
            gc_reset_evt_o <= pulse.gc_reset;
            prog_evt_o     <= pulse.prog;
            byte_evt_o     <= pulse.rx_byte;
            if (pulse.addr)
                rw_o <= rw;
            if (take_data)
                rx_data_o <= data;
            if (pulse.prog | pulse.gc_reset)
                own_addr_o <= own;
        end
    end

    // ----------------------------------------------------------------
    // Checks on the link side
    // ----------------------------------------------------------------
    default clocking cb @(posedge lnk_clk_i);
    endclocking
    default disable iff (!lrst_n || !rst_n_i);

    AST_START_RESET: assert property (
        start_c |=> (st == sbsa_pkg::S_ADDR) && (cnt == 4'h0) && !oe)
        else $error("start did not restart address phase");

    AST_STOP_IDLE: assert property (
        (stop_c && !start_c) |=> (st == sbsa_pkg::S_IDLE) && !oe)
        else $error("stop did not release the bus");

    AST_START_BYTE: assert property (
        (decide && !start_c && !stop_c && (st == sbsa_pkg::S_ADDR) &&
         (sh == sbsa_pkg::SBSA_START_BYT)) |=> !oe [*2])
        else $error("start byte acknowledged");

    AST_OWN_ACK: assert property (
        (decide && !start_c && !stop_c && (st == sbsa_pkg::S_ADDR) &&
         hit_own) |=> oe && ack_us && (rw == $past(sh[0])))
        else $error("own address not acknowledged");

    AST_RESERVED: assert property (
        (decide && !start_c && !stop_c && (st == sbsa_pkg::S_ADDR) &&
         ((sh[7:1] == sbsa_pkg::SBSA_EXT_ADDR) ||
          (sh[7:1] == sbsa_pkg::SBSA_TRIW_ADDR) ||
          (sh[7:1] == sbsa_pkg::SBSA_ALT_ADDR)))
        |=> (st == sbsa_pkg::S_IDLE) && !oe)
        else $error("reserved address claimed");

    AST_GC_OFF: assert property (
        (decide && !start_c && !stop_c && (st == sbsa_pkg::S_ADDR) &&
         (sh == sbsa_pkg::SBSA_GC_BYTE) && !gc_en) |=> !oe)
        else $error("general call acked while disabled");

    AST_GC_RESET: assert property (
        (decide && !start_c && !stop_c && (st == sbsa_pkg::S_GC2) &&
         (sh == sbsa_pkg::SBSA_GC_RESET))
        |=> (prog == $past(hw_s)) && (st == sbsa_pkg::S_NACK))
        else $error("reset code did not load address");

    AST_ACK_HOLD: assert property (
        (ack_us && scl_hi && (cnt == sbsa_pkg::SBSA_BIT_END)) |-> oe)
        else $error("data released inside own ack");

    AST_BYTE_LEN: assert property (
        cnt <= sbsa_pkg::SBSA_BIT_END)
        else $error("bit counter out of range");

    AST_RELEASED: assert property (
        $rose(lrst_n) |-> !oe)
        else $error("line driven at reset release");

endmodule
